// ==== design/bit_set_compare_skip_exec.sv ====
// Execution logic for bit set, compare-skip and flag-test instructions
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "bit_exec_consts.svh"
module bit_set_compare_skip_exec
  import bit_exec_pkg::*;
#(
  parameter int MEM_WORDS  = `BX_MEM_WORDS,
  parameter int MEM_ADDR_W = `BX_MEM_ADDR_W
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  // Instruction issue
  input  wire logic                  op_valid,
  input  wire logic [2:0]            op_code,
  input  wire logic [3:0]            op_imm,
  input  wire logic [3:0]            acc,
  input  wire logic [2:0]            y_reg,
  input  wire logic [MEM_ADDR_W-1:0] data_pointer,
  // Flag sources
  input  wire logic                  ext_int0_event,
  input  wire logic                  high_ref_set,
  // Register port
  input  wire logic [3:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  // Outputs
  output logic      [7:0]            port_d,
  output logic                       skip_q,
  output logic                       high_order_ref_flag,
  output logic                       ext_int0_request_flag,
  output logic                       irq
);
  localparam logic [3:0] A_CTRL   = `BX_ADDR_CTRL;
  localparam logic [3:0] A_PORT_D = `BX_ADDR_PORT_D;
  localparam logic [3:0] A_STATUS = `BX_ADDR_STATUS;
  localparam logic [3:0] A_MASK   = `BX_ADDR_MASK;
  localparam logic [3:0] A_MEM_A  = `BX_ADDR_MEM_A;
  localparam logic [3:0] A_MEM_D  = `BX_ADDR_MEM_D;
  localparam logic [3:0] A_FLAGS  = `BX_ADDR_FLAGS;

  bx_op_t                  op;
  logic [3:0]              mem_q [MEM_WORDS];
  logic [3:0]              interrupt_control_reg_one;
  logic                    ext_int0_test_gate_bit;
  logic [MEM_ADDR_W-1:0]   mem_ptr_q;
  logic [`BX_IRQ_BITS-1:0] status_q;
  logic [`BX_IRQ_BITS-1:0] mask_q;
  logic                    issue;
  logic                    live;
  logic                    skip_req;
  logic                    ext_sync1_q;
  logic                    ext_sync2_q;
  logic                    ext_prev_q;
  logic                    ext_rise;
  logic                    test_clear;
  logic [3:0]              mem_at_dp;

  // Checks share the core clock and are idle in reset
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  function automatic logic [3:0] bit_mask4(input logic [1:0] j);
    bit_mask4 = 4'h1 << j;
  endfunction

  assign op        = bx_op_t'(op_code);
  assign issue     = op_valid;
  // Skipped instruction is issued but has no effect
  assign live      = op_valid && !skip_q;
  assign mem_at_dp = mem_q[data_pointer];
  assign ext_int0_test_gate_bit =
    interrupt_control_reg_one[`BX_GATE_BIT_POS];

  always_comb begin
    skip_req = 1'b0;
    if (live) begin
      case (op)
        op_cmp_imm_t:   skip_req = (acc == op_imm);
        op_cmp_mem_t:   skip_req = (acc == mem_at_dp);
        op_ext0_test_t: skip_req = !ext_int0_test_gate_bit &&
                                   ext_int0_request_flag;
        default:        skip_req = 1'b0;
      endcase
    end
  end

  skip_latch skip_latch_inst (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .issue    (issue),
    .skip_req (skip_req),
    .skip_q   (skip_q)
  );

  sequence s_skipped_slot;
    op_valid && skip_q;
  endsequence

  a_cmp_imm_skip: assert property (
    live && op == op_cmp_imm_t |=>
    skip_q == ($past(acc) == $past(op_imm)))
    else $error("immediate compare skip wrong");

  a_cmp_mem_skip: assert property (
    live && op == op_cmp_mem_t |=>
    skip_q == ($past(acc) == $past(mem_at_dp)))
    else $error("memory compare skip wrong");

  // A skipped slot must not arm a second skip
  a_skip_consumed: assert property (
    s_skipped_slot |=> !skip_q)
    else $error("skip latch not consumed");

  a_skipped_inert: assert property (
    s_skipped_slot ##0 op == op_set_port_bit_t ##0 !reg_wr |=>
    $stable(port_d))
    else $error("skipped instruction changed port D");

  // External pin is asynchronous
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ext_sync1_q <= 1'b0;
      ext_sync2_q <= 1'b0;
      ext_prev_q  <= 1'b0;
    end else begin
      ext_sync1_q <= ext_int0_event;
      ext_sync2_q <= ext_sync1_q;
      ext_prev_q  <= ext_sync2_q;
    end
  end
  assign ext_rise = ext_sync2_q && !ext_prev_q;

  assign test_clear = live && op == op_ext0_test_t &&
                      !ext_int0_test_gate_bit;

  // A new edge in the clearing cycle wins
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ext_int0_request_flag <= 1'b0;
    end else if (ext_rise) begin
      ext_int0_request_flag <= 1'b1;
    end else if (test_clear) begin
      ext_int0_request_flag <= 1'b0;
    end
  end

  sequence s_flag_test;
    live && op == op_ext0_test_t;
  endsequence

  a_flag_test_skip: assert property (
    s_flag_test ##0 !ext_int0_test_gate_bit |=>
    skip_q == $past(ext_int0_request_flag))
    else $error("flag test skip wrong");

  a_flag_test_clr: assert property (
    s_flag_test ##0 !ext_int0_test_gate_bit ##0 !ext_rise |=>
    !ext_int0_request_flag)
    else $error("request flag not cleared");

  // A pin edge in the same cycle may still set the flag
  a_flag_test_nop: assert property (
    s_flag_test ##0 ext_int0_test_gate_bit ##0 !ext_rise |=>
    !skip_q && $stable(ext_int0_request_flag))
    else $error("gated flag test not a no-op");

  a_edge_sets_flag: assert property (
    ext_rise |=> ext_int0_request_flag)
    else $error("pin edge lost");

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      high_order_ref_flag <= 1'b0;
    end else if (live && op == op_clr_ref_t) begin
      high_order_ref_flag <= 1'b0;
    end else if (high_ref_set) begin
      high_order_ref_flag <= 1'b1;
    end
  end

  a_clr_ref_flag: assert property (
    live && op == op_clr_ref_t |=> !high_order_ref_flag && !skip_q)
    else $error("reference flag clear wrong");

  a_ref_flag_set: assert property (
    high_ref_set && !(live && op == op_clr_ref_t) |=> high_order_ref_flag)
    else $error("reference flag not set");

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      port_d <= `BX_PORT_D_RESET;
    end else if (live && op == op_set_port_bit_t) begin
      port_d[y_reg] <= 1'b1;
    end else if (reg_wr && reg_addr == A_PORT_D) begin
      port_d <= reg_wdata;
    end
  end

  sequence s_set_port;
    live && op == op_set_port_bit_t;
  endsequence

  // Other pins must keep their level when one bit is set
  a_port_bit_set: assert property (
    s_set_port |=> port_d == ($past(port_d) | (8'h01 << $past(y_reg))))
    else $error("port bit not set");

  // Memory has no reset; program initialises it
  always_ff @(posedge ref_clk) begin
    if (live && op == op_set_mem_bit_t) begin
      mem_q[data_pointer] <= mem_at_dp |
                             bit_mask4(op_imm[1:0]);
    end else if (reg_wr && reg_addr == A_MEM_D) begin
      mem_q[mem_ptr_q] <= reg_wdata[3:0];
    end
  end

  sequence s_set_mem;
    live && op == op_set_mem_bit_t;
  endsequence

  // Neighbouring bits of the nibble must survive the set
  a_set_mem_bit: assert property (
    s_set_mem |=> mem_q[$past(data_pointer)] ==
    ($past(mem_at_dp) | (4'h1 << $past(op_imm[1:0]))))
    else $error("memory bit not set");

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      interrupt_control_reg_one <= `BX_CTRL_ONE_RESET;
      mask_q                    <= '0;
      mem_ptr_q                 <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        A_CTRL:  interrupt_control_reg_one <= reg_wdata[3:0];
        A_MASK:  mask_q    <= reg_wdata[`BX_IRQ_BITS-1:0];
        A_MEM_A: mem_ptr_q <= reg_wdata[MEM_ADDR_W-1:0];
        default: mask_q    <= mask_q;
      endcase
    end
  end

  // Gate must follow bit 0 of every control write
  a_gate_is_bit0: assert property (
    reg_wr && reg_addr == A_CTRL |=>
    ext_int0_test_gate_bit == $past(reg_wdata[0]))
    else $error("gate bit misplaced");

  a_gate_steady: assert property (
    !(reg_wr && reg_addr == A_CTRL) |=> $stable(ext_int0_test_gate_bit))
    else $error("gate bit moved without a write");

  // Sticky events; read clears but a same-cycle event survives
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      status_q <= '0;
    end else begin
      status_q <= ((reg_rd && reg_addr == A_STATUS) ? '0 : status_q)
                  | {skip_req, ext_rise};
    end
  end
  assign irq = |(status_q & mask_q);

  sequence s_status_read;
    reg_rd && reg_addr == A_STATUS;
  endsequence

  // Read clears only when no event lands in the same cycle
  a_status_clear: assert property (
    s_status_read ##0 !ext_rise ##0 !skip_req |=> status_q == '0)
    else $error("status not cleared by read");

  a_status_sticky: assert property (
    ext_rise |=> status_q[`BX_IRQ_STATUS_BIT_EXT0])
    else $error("pin event not recorded");

  a_status_skip: assert property (
    skip_req |=> status_q[`BX_IRQ_STATUS_BIT_SKIP])
    else $error("skip event not recorded");

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        A_CTRL:   reg_rdata <= {4'h0, interrupt_control_reg_one};
        A_PORT_D: reg_rdata <= port_d;
        A_STATUS: reg_rdata <= {6'h00, status_q};
        A_MASK:   reg_rdata <= {6'h00, mask_q};
        A_MEM_A:  reg_rdata <= 8'(mem_ptr_q);
        A_MEM_D:  reg_rdata <= {4'h0, mem_q[mem_ptr_q]};
        A_FLAGS:  reg_rdata <= {5'h00, skip_q, high_order_ref_flag,
                                ext_int0_request_flag};
        default:  reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Read data stands for one cycle only
  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
endmodule

// ==== design/bit_exec_consts.svh ====
// Constants for the bit set, compare and skip execution block
`ifndef BIT_EXEC_CONSTS_SVH
`define BIT_EXEC_CONSTS_SVH
`define BX_IRQ_STATUS_BIT_EXT0  0
`define BX_IRQ_STATUS_BIT_SKIP  1
`define BX_IRQ_BITS             2
`define BX_GATE_BIT_POS         0
`define BX_CTRL_ONE_RESET       4'h0
`define BX_PORT_D_RESET         8'h00
`define BX_MEM_WORDS            16
`define BX_MEM_ADDR_W           4
`define BX_ADDR_CTRL            4'h0
`define BX_ADDR_PORT_D          4'h1
`define BX_ADDR_STATUS          4'h2
`define BX_ADDR_MASK            4'h3
`define BX_ADDR_MEM_A           4'h4
`define BX_ADDR_MEM_D           4'h5
`define BX_ADDR_FLAGS           4'h6
`endif

// ==== design/bit_exec_pkg.sv ====
// Types for the bit set, compare and skip execution block
package bit_exec_pkg;
  typedef enum logic [2:0] {
    op_none_t         = 3'h0,
    op_set_mem_bit_t  = 3'h1,
    op_set_port_bit_t = 3'h2,
    op_cmp_imm_t      = 3'h3,
    op_cmp_mem_t      = 3'h4,
    op_ext0_test_t    = 3'h5,
    op_clr_ref_t      = 3'h6
  } bx_op_t;
endpackage

// ==== design/skip_latch.sv ====
// One-instruction skip latch for the execution block
`timescale 1ns/1ps
module skip_latch (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // Control
  input  wire logic issue,
  input  wire logic skip_req,
  // Status
  output logic      skip_q
);
  // Next issued instruction is the skipped one; it consumes the latch
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      skip_q <= 1'b0;
    end else if (issue) begin
      skip_q <= skip_req && !skip_q;
    end
  end
endmodule

// ==== verification/bit_set_compare_skip_exec_test.sv ====
// Directed testbench for the bit set, compare and skip execution block
`timescale 1ns/1ps
module bit_set_compare_skip_exec_test
  import bit_exec_pkg::*;
;
  logic       ref_clk, rst_b, op_valid, ext_int0_event, high_ref_set;
  logic [2:0] op_code, y_reg;
  logic [3:0] op_imm, acc, data_pointer, reg_addr, mexp;
  logic [7:0] reg_wdata, reg_rdata, port_d, pexp, d;
  logic       reg_wr, reg_rd, skip_q, high_order_ref_flag;
  logic       ext_int0_request_flag, irq;
  int         error_cnt, check_count, cyc;

  bit_set_compare_skip_exec bit_set_compare_skip_exec_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .op_valid(op_valid),
    .op_code(op_code), .op_imm(op_imm), .acc(acc), .y_reg(y_reg),
    .data_pointer(data_pointer), .ext_int0_event(ext_int0_event),
    .high_ref_set(high_ref_set), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .port_d(port_d), .skip_q(skip_q),
    .high_order_ref_flag(high_order_ref_flag),
    .ext_int0_request_flag(ext_int0_request_flag), .irq(irq));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic wrap_up();
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard, well above the roughly 140 cycles the tests need
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic issue(input bx_op_t op, input logic [3:0] imm,
                       input logic [3:0] a, input logic [2:0] y);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_code  <= op;
    op_imm   <= imm;
    acc      <= a;
    y_reg    <= y;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // Pin is resynchronised, so allow several cycles for the flag
  task automatic pulse_ext0();
    @(posedge ref_clk);
    ext_int0_event <= 1'b1;
    repeat (2) @(posedge ref_clk);
    ext_int0_event <= 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
  endtask

  initial begin
    {op_valid, ext_int0_event, high_ref_set, reg_wr, reg_rd} = '0;
    {op_code, y_reg, op_imm, acc, reg_addr, reg_wdata} = '0;
    data_pointer = 4'h5;
    {error_cnt, check_count} = '0;
    rst_b = 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    chk8(port_d, 8'h00);
    chk1(skip_q, 1'b0);
    chk1(irq, 1'b0);
    pexp = 8'h00;
    for (int i = 0; i < 8; i++) begin
      issue(op_set_port_bit_t, 4'h0, 4'h0, i[2:0]);
      pexp = pexp | (8'h01 << i);
      chk8(port_d, pexp);
    end
    wr(4'h4, 8'h05);
    wr(4'h5, 8'h00);
    rd(4'h4, d);
    chk8(d, 8'h05);
    mexp = 4'h0;
    // Immediate bit 3 set to show only the low two select the bit
    for (int j = 0; j < 4; j++) begin
      issue(op_set_mem_bit_t, {2'b10, j[1:0]}, 4'h0, 3'h0);
      rd(4'h5, d);
      mexp = mexp | (4'h1 << j);
      chk8(d, {4'h0, mexp});
    end
    wr(4'h1, 8'h00);
    issue(op_cmp_imm_t, 4'hF, 4'hF, 3'h0);
    chk1(skip_q, 1'b1);
    issue(op_set_port_bit_t, 4'h0, 4'h0, 3'h3);
    chk8(port_d, 8'h00);
    chk1(skip_q, 1'b0);
    issue(op_cmp_imm_t, 4'h0, 4'hF, 3'h0);
    chk1(skip_q, 1'b0);
    issue(op_set_port_bit_t, 4'h0, 4'h0, 3'h3);
    chk8(port_d, 8'h08);
    issue(op_cmp_mem_t, 4'h0, 4'hF, 3'h0);
    chk1(skip_q, 1'b1);
    issue(op_none_t, 4'h0, 4'h0, 3'h0);
    issue(op_cmp_mem_t, 4'h0, 4'hE, 3'h0);
    chk1(skip_q, 1'b0);
    pulse_ext0();
    chk1(ext_int0_request_flag, 1'b1);
    issue(op_ext0_test_t, 4'h0, 4'h0, 3'h0);
    chk1(skip_q, 1'b1);
    chk1(ext_int0_request_flag, 1'b0);
    issue(op_none_t, 4'h0, 4'h0, 3'h0);
    issue(op_ext0_test_t, 4'h0, 4'h0, 3'h0);
    chk1(skip_q, 1'b0);
    wr(4'h0, 8'h01);
    pulse_ext0();
    issue(op_ext0_test_t, 4'h0, 4'h0, 3'h0);
    chk1(skip_q, 1'b0);
    chk1(ext_int0_request_flag, 1'b1);
    // Other control bits high: only bit 0 may gate the test
    wr(4'h0, 8'hFE);
    issue(op_ext0_test_t, 4'h0, 4'h0, 3'h0);
    chk1(skip_q, 1'b1);
    chk1(ext_int0_request_flag, 1'b0);
    rd(4'h0, d);
    chk8(d, 8'h0E);
    issue(op_none_t, 4'h0, 4'h0, 3'h0);
    @(posedge ref_clk);
    high_ref_set <= 1'b1;
    @(posedge ref_clk);
    high_ref_set <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk1(high_order_ref_flag, 1'b1);
    issue(op_clr_ref_t, 4'h0, 4'h0, 3'h0);
    chk1(high_order_ref_flag, 1'b0);
    chk1(skip_q, 1'b0);
    rd(4'h2, d);
    wr(4'h3, 8'h01);
    chk1(irq, 1'b0);
    pulse_ext0();
    chk1(irq, 1'b1);
    rd(4'h2, d);
    chk8(d, 8'h01);
    chk1(irq, 1'b0);
    wr(4'h3, 8'h00);
    pulse_ext0();
    chk1(irq, 1'b0);
    rd(4'h2, d);
    chk8(d, 8'h01);
    // Read data must be gone one cycle later
    @(posedge ref_clk);
    #1;
    chk8(reg_rdata, 8'h00);
    wr(4'h3, 8'h02);
    issue(op_cmp_imm_t, 4'h7, 4'h7, 3'h0);
    chk1(irq, 1'b1);
    issue(op_none_t, 4'h0, 4'h0, 3'h0);
    rd(4'h2, d);
    chk8(d, 8'h02);
    rd(4'h6, d);
    chk8(d, 8'h01);
    rd(4'hF, d);
    chk8(d, 8'h00);
    wrap_up();
  end
endmodule
